// ### logic/afe_ctrl_pkg.sv
// shared constants and types of the video front end control registers
package afe_ctrl_pkg;

  // =====================================================================
  // widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PIX_W  = 48;
  localparam int unsigned OFS_W  = 7;
  localparam int unsigned IDX_W  = 6;
  localparam int unsigned NCHAN  = 3;

  // =====================================================================
  // register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_RED_OFS   = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_GREEN_OFS = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_BLUE_OFS  = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_SYNC_CTRL = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_CLAMP_CTRL = 6'h0f;
  localparam logic [IDX_W-1:0] IDX_STATUS    = 6'h14;

  // =====================================================================
  // values after reset
  localparam logic [OFS_W-1:0] OFS_RST   = 7'h40;
  localparam logic [7:0]       SYNC_RST  = 8'h40;
  localparam logic [7:0]       CLAMP_RST = 8'h4e;

  // =====================================================================
  // status register bit positions
  localparam int unsigned ST_LINE_ACT  = 7;
  localparam int unsigned ST_LINE_SRC  = 6;
  localparam int unsigned ST_LINE_POL  = 5;
  localparam int unsigned ST_FRAME_ACT = 4;
  localparam int unsigned ST_FRAME_SRC = 3;
  localparam int unsigned ST_GREEN_ACT = 1;

  // =====================================================================
  // register layouts, msb first
  typedef struct packed {
    logic line_pol_ovr;
    logic line_pol_high;
    logic line_out_low;
    logic line_src_ovr;
    logic line_src_user;
    logic frame_out_true;
    logic frame_src_ovr;
    logic frame_src_user;
  } sync_ctrl_t;

  typedef struct packed {
    logic clamp_ext;
    logic clamp_pol_low;
    logic coast_from_frame;
    logic coast_pol_ovr;
    logic coast_pol_high;
    logic seek_allow;
    logic full_power_down_n;
    logic rsvd;
  } clamp_ctrl_t;

  // activity flags of the three sync inputs
  typedef struct packed {
    logic line;
    logic green;
    logic frame;
  } sync_act_t;

  // output power states
  typedef enum logic [2:0] {
    st_run  = 3'b001,
    st_seek = 3'b010,
    st_down = 3'b100
  } pwr_state_t;

endpackage : afe_ctrl_pkg

// ### logic/sync_select.sv
// sync source choice between a pin and an alternate source
`timescale 1ns/1ps
module sync_select #(
  parameter bit TIE_USER = 1'b0
) (
  // candidate sources and their activity
  input  wire logic pin_sync,
  input  wire logic alt_sync,
  input  wire logic pin_act,
  input  wire logic alt_act,
  // user override
  input  wire logic src_ovr,
  input  wire logic src_user,
  // choice
  output logic      auto_sel,
  output logic      eff_sel,
  output logic      sync_sel
);

  // =====================================================================
  // automatic pick: lone active source wins; a tie takes the user bit if TIE_USER, else pin
  always_comb begin
    if (pin_act && alt_act) begin
      auto_sel = TIE_USER & src_user;
    end else begin
      auto_sel = alt_act & ~pin_act;
    end
  end

  // override takes the user bit unconditionally
  assign eff_sel  = src_ovr ? src_user : auto_sel;
  assign sync_sel = eff_sel ? alt_sync : pin_sync;

endmodule : sync_select

// ### logic/out_stage.sv
// registered output stage with its own output enable
`timescale 1ns/1ps
module out_stage #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // next value and enable
  input  wire logic [W-1:0] val_d,
  input  wire logic         en_d,
  // pad side
  output logic      [W-1:0] val_q,
  output logic              oe_q
);

  // =====================================================================
  // held while ce is low, released from reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_q <= '0;
      oe_q  <= 1'b0;
    end else if (ce) begin
      val_q <= val_d;
      oe_q  <= en_d;
    end
  end

endmodule : out_stage

// ### logic/afe_ctrl_regs.sv
// offset, sync, clamp, coast and power control registers with apb access
//
// Functional notes
// - three seven-bit channel offsets held in bits 7:1
// - each offset resets to 1000000, meaning no correction
// - offsets above 40h darken, below brighten; scale follows channel gain
// - sync bit 7 picks detected or user line input polarity
// - sync bit 6 is user line polarity, 1 active high, resets 1
// - sync bit 5 set makes line sync output active low
// - sync bit 4 set forces line source from bit 3
// - bit 3: 0 pin, 1 green slicer; used on override or both active
// - sync bit 2 clear inverts the frame sync output
// - sync bit 1 set forces frame source from bit 0
// - bit 0: 0 frame pin, 1 separator; only with bit 1 set
// - clamp bit 7 picks internal counters or external clamp strobe
// - clamp bit 6 sets strobe polarity, 1 active low, resets 1
// - bit 5 picks coast from coast pin or from frame sync
// - bit 4 picks detected or user coast polarity
// - bit 3 user coast polarity, 1 high, resets 1, pin source only
// - bit 2 allows low power seek while syncs idle, resets 1
// - seek floats sync, pixel clock and 48 data outputs; slicer stays
// - seek keeps detection and register access alive
// - bit 1 low powers the device down, high runs normally
// - power down floats the same outputs, registers stay usable
// - status bit 6 reports the automatic line source
// - status bit 3 reports the automatic frame source
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module afe_ctrl_regs (
  // clock, reset, enable
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              ce,
  // apb slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [afe_ctrl_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [afe_ctrl_pkg::DATA_W-1:0]   pwdata,
  output logic      [afe_ctrl_pkg::DATA_W-1:0]   prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // sync inputs and detection results
  input  wire logic                              line_sync_in,
  input  wire logic                              green_sync_in,
  input  wire logic                              frame_sync_in,
  input  wire logic                              sep_frame_sync,
  input  wire afe_ctrl_pkg::sync_act_t           sync_act,
  input  wire logic                              det_line_pol_high,
  input  wire logic                              det_coast_pol_high,
  // clamp and coast inputs
  input  wire logic                              clamp_strobe_in,
  input  wire logic                              int_clamp,
  input  wire logic                              coast_in,
  // pixel path
  input  wire logic                              pix_clk_in,
  input  wire logic [afe_ctrl_pkg::PIX_W-1:0]    pix_data_in,
  // analog controls
  output logic      [afe_ctrl_pkg::OFS_W-1:0]    red_offset_out,
  output logic      [afe_ctrl_pkg::OFS_W-1:0]    green_offset_out,
  output logic      [afe_ctrl_pkg::OFS_W-1:0]    blue_offset_out,
  output logic                                   clamp_active,
  output logic                                   coast_active,
  output logic                                   low_power,
  // output pads
  output logic                                   line_sync_out,
  output logic                                   line_sync_oe,
  output logic                                   frame_sync_out,
  output logic                                   frame_sync_oe,
  output logic      [1:0]                        pixel_clock_out,
  output logic                                   pixel_clock_oe,
  output logic      [afe_ctrl_pkg::PIX_W-1:0]    data_out,
  output logic                                   data_oe,
  output logic                                   green_slicer_out
);

  // =====================================================================
  // address decoding

  function automatic logic [afe_ctrl_pkg::IDX_W-1:0] reg_idx(
    input logic [afe_ctrl_pkg::ADDR_W-1:0] addr);
    reg_idx = addr[afe_ctrl_pkg::ADDR_W-1:2];
  endfunction : reg_idx

  function automatic logic is_mapped(input logic [afe_ctrl_pkg::ADDR_W-1:0] addr);
    logic [afe_ctrl_pkg::IDX_W-1:0] i;
    i = reg_idx(addr);
    is_mapped = (addr[1:0] == 2'h0) &&
                (((i >= afe_ctrl_pkg::IDX_RED_OFS) && (i <= afe_ctrl_pkg::IDX_CLAMP_CTRL))
                 || (i == afe_ctrl_pkg::IDX_STATUS));
  endfunction : is_mapped

  logic                             setup_ph;
  logic                             access_ph;
  logic                             wr_en;
  logic [afe_ctrl_pkg::IDX_W-1:0]   idx;
  logic [afe_ctrl_pkg::OFS_W-1:0]   ofs_q [afe_ctrl_pkg::NCHAN];
  afe_ctrl_pkg::sync_ctrl_t         sync_q;
  afe_ctrl_pkg::clamp_ctrl_t        clamp_q;
  logic [7:0]                       status_q;
  logic [7:0]                       rd_byte;
  logic [afe_ctrl_pkg::DATA_W-1:0]  prdata_q;
  afe_ctrl_pkg::pwr_state_t         pwr_q;
  afe_ctrl_pkg::pwr_state_t         pwr_d;

  // zero wait states; ce low stretches the access phase
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign idx       = reg_idx(paddr);
  assign pready    = ce;
  assign pslverr   = access_ph & ~is_mapped(paddr);
  assign wr_en     = access_ph & pwrite & ce & is_mapped(paddr);
  assign prdata    = prdata_q;

  // =====================================================================
  // offset registers, one per channel

  genvar g;
  generate
    for (g = 0; g < afe_ctrl_pkg::NCHAN; g++) begin : g_ofs
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ofs_q[g] <= afe_ctrl_pkg::OFS_RST;
        end else if (wr_en && (idx == afe_ctrl_pkg::IDX_RED_OFS + 6'(g))) begin
          ofs_q[g] <= pwdata[7:1];
        end
      end
    end
  endgenerate

  // raw code to the offset dac, gain scales it
  assign red_offset_out   = ofs_q[0];
  assign green_offset_out = ofs_q[1];
  assign blue_offset_out  = ofs_q[2];

  // =====================================================================
  // sync and clamp control registers

  // sync control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= afe_ctrl_pkg::SYNC_RST;
    end else if (wr_en && (idx == afe_ctrl_pkg::IDX_SYNC_CTRL)) begin
      sync_q <= pwdata[7:0];
    end
  end

  // clamp, coast and power register; reserved bit 0 stays zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clamp_q <= afe_ctrl_pkg::CLAMP_RST;
    end else if (wr_en && (idx == afe_ctrl_pkg::IDX_CLAMP_CTRL)) begin
      clamp_q <= {pwdata[7:1], 1'b0};
    end
  end

  // =====================================================================
  // sync source selection

  logic line_auto;
  logic line_eff;
  logic line_raw;
  logic frame_auto;
  logic frame_eff;
  logic frame_raw;
  logic line_pol_eff;
  logic line_hi;
  logic coast_pol_eff;

  // line override, user bit also breaks a tie
  sync_select #(.TIE_USER(1'b1)) u_line_sel (
    .pin_sync (line_sync_in),
    .alt_sync (green_sync_in),
    .pin_act  (sync_act.line),
    .alt_act  (sync_act.green),
    .src_ovr  (sync_q.line_src_ovr),
    .src_user (sync_q.line_src_user),
    .auto_sel (line_auto),
    .eff_sel  (line_eff),
    .sync_sel (line_raw)
  );

  // frame override, user bit only when forced
  sync_select #(.TIE_USER(1'b0)) u_frame_sel (
    .pin_sync (frame_sync_in),
    .alt_sync (sep_frame_sync),
    .pin_act  (sync_act.frame),
    .alt_act  (sync_act.green),
    .src_ovr  (sync_q.frame_src_ovr),
    .src_user (sync_q.frame_src_user),
    .auto_sel (frame_auto),
    .eff_sel  (frame_eff),
    .sync_sel (frame_raw)
  );

  // polarity override, then normalise to active high
  assign line_pol_eff = sync_q.line_pol_ovr ? sync_q.line_pol_high : det_line_pol_high;
  assign line_hi      = line_raw ^ ~line_pol_eff;

  // =====================================================================
  // clamp and coast

  // strobe polarity matters only for external timing
  assign clamp_active = clamp_q.clamp_ext ? (clamp_strobe_in ^ clamp_q.clamp_pol_low)
                                          : int_clamp;

  // coast polarity, user value only for the pin source
  assign coast_pol_eff = clamp_q.coast_pol_ovr ? clamp_q.coast_pol_high
                                               : det_coast_pol_high;
  // coast from pin or from frame sync
  assign coast_active = clamp_q.coast_from_frame ? frame_raw
                                                 : (coast_in ^ ~coast_pol_eff);

  // =====================================================================
  // power state; registers stay writable in every state

  // seek needs permission and idle syncs, power down wins
  always_comb begin
    case (pwr_q)
      afe_ctrl_pkg::st_run,
      afe_ctrl_pkg::st_seek,
      afe_ctrl_pkg::st_down: begin
        if (!clamp_q.full_power_down_n) begin
          pwr_d = afe_ctrl_pkg::st_down;
        end else if (clamp_q.seek_allow && (sync_act == '0)) begin
          pwr_d = afe_ctrl_pkg::st_seek;
        end else begin
          pwr_d = afe_ctrl_pkg::st_run;
        end
      end
      default: pwr_d = afe_ctrl_pkg::st_run;
    endcase
  end

  // power state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q <= afe_ctrl_pkg::st_run;
    end else if (ce) begin
      pwr_q <= pwr_d;
    end
  end

  assign low_power = (pwr_q != afe_ctrl_pkg::st_run);

  // =====================================================================
  // output pads

  logic [1:0] sync_pads;

  // outputs float outside run, slicer excluded
  out_stage #(.W(2)) u_sync_pads (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .val_d   ({line_hi ^ sync_q.line_out_low, frame_raw ^ ~sync_q.frame_out_true}),
    .en_d    (~low_power),
    .val_q   (sync_pads),
    .oe_q    (line_sync_oe)
  );

  assign line_sync_out  = sync_pads[1];
  assign frame_sync_out = sync_pads[0];
  assign frame_sync_oe  = line_sync_oe;

  // data bus floats with the syncs
  out_stage #(.W(afe_ctrl_pkg::PIX_W)) u_data_pads (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .val_d   (pix_data_in),
    .en_d    (~low_power),
    .val_q   (data_out),
    .oe_q    (data_oe)
  );

  // clock pair passes straight through to keep its edges
  assign pixel_clock_out = {~pix_clk_in, pix_clk_in};
  assign pixel_clock_oe  = data_oe;

  // slicer output is driven in every power state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      green_slicer_out <= 1'b0;
    end else if (ce) begin
      green_slicer_out <= green_sync_in;
    end
  end

  // =====================================================================
  // status and read path

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 8'h00;
    end else if (ce) begin
      status_q <= '0;
      status_q[afe_ctrl_pkg::ST_LINE_ACT]  <= sync_act.line;
      status_q[afe_ctrl_pkg::ST_LINE_SRC]  <= line_auto;
      status_q[afe_ctrl_pkg::ST_LINE_POL]  <= det_line_pol_high;
      status_q[afe_ctrl_pkg::ST_FRAME_ACT] <= sync_act.frame;
      status_q[afe_ctrl_pkg::ST_FRAME_SRC] <= frame_auto;
      status_q[afe_ctrl_pkg::ST_GREEN_ACT] <= sync_act.green;
    end
  end

  // read mux; unmapped reads return zero
  always_comb begin
    case (idx)
      afe_ctrl_pkg::IDX_RED_OFS:    rd_byte = {ofs_q[0], 1'b0};
      afe_ctrl_pkg::IDX_GREEN_OFS:  rd_byte = {ofs_q[1], 1'b0};
      afe_ctrl_pkg::IDX_BLUE_OFS:   rd_byte = {ofs_q[2], 1'b0};
      afe_ctrl_pkg::IDX_SYNC_CTRL:  rd_byte = sync_q;
      afe_ctrl_pkg::IDX_CLAMP_CTRL: rd_byte = clamp_q;
      afe_ctrl_pkg::IDX_STATUS:     rd_byte = status_q;
      default:                      rd_byte = 8'h00;
    endcase
    if (paddr[1:0] != 2'h0) begin
      rd_byte = 8'h00;
    end
  end

  // read data latched in the setup cycle, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (ce && setup_ph && !pwrite) begin
      prdata_q <= {24'h000000, rd_byte};
    end
  end

  // =====================================================================
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_offset_write: assert property (
    (wr_en && idx == afe_ctrl_pkg::IDX_GREEN_OFS) |=> green_offset_out == $past(pwdata[7:1]))
    else $error("green offset write not stored");

  a_offset_reset: assert property (
    @(posedge pclk) disable iff (1'b0)
    !$past(presetn) |-> red_offset_out == afe_ctrl_pkg::OFS_RST &&
                        blue_offset_out == afe_ctrl_pkg::OFS_RST)
    else $error("offset not at reset code");

  a_line_polarity: assert property (
    ce && !low_power && sync_q.line_pol_ovr |=>
      line_sync_out == ($past(line_raw) ^ ~$past(sync_q.line_pol_high)
                        ^ $past(sync_q.line_out_low)))
    else $error("line sync output polarity wrong");

  a_line_override: assert property (
    sync_q.line_src_ovr |-> line_eff == sync_q.line_src_user)
    else $error("line source override ignored");

  a_line_tie: assert property (
    !sync_q.line_src_ovr && sync_act.line && sync_act.green |-> line_eff == sync_q.line_src_user)
    else $error("line tie not broken by user bit");

  a_frame_output: assert property (
    presetn && ce ##1 ce |-> frame_sync_out == ($past(frame_raw) ^ ~$past(sync_q.frame_out_true)))
    else $error("frame sync inversion wrong");

  a_frame_source: assert property (
    !sync_q.frame_src_ovr |-> frame_eff == frame_auto)
    else $error("frame user select leaked without override");

  a_clamp_source: assert property (
    !clamp_q.clamp_ext |-> clamp_active == int_clamp)
    else $error("clamp not from internal counter");

  a_coast_frame: assert property (
    clamp_q.coast_from_frame |-> coast_active == frame_raw)
    else $error("coast not from frame sync");

  a_seek_blocked: assert property (
    ce && !clamp_q.seek_allow |=> pwr_q != afe_ctrl_pkg::st_seek)
    else $error("seek entered without permission");

  a_float_outputs: assert property (
    ce && low_power |=> !data_oe && !line_sync_oe && !pixel_clock_oe)
    else $error("outputs driven in low power");

  a_power_down: assert property (
    ce && !clamp_q.full_power_down_n |=> pwr_q == afe_ctrl_pkg::st_down)
    else $error("power down not entered");

  a_status_auto: assert property (
    presetn && ce |=> status_q[afe_ctrl_pkg::ST_LINE_SRC] == $past(line_auto) &&
           status_q[afe_ctrl_pkg::ST_FRAME_SRC] == $past(frame_auto))
    else $error("status does not follow automatic source");

  c_seek_entry: cover property (ce && pwr_q == afe_ctrl_pkg::st_seek);
  c_power_down: cover property (pwr_q == afe_ctrl_pkg::st_down ##1 wr_en);
  c_line_slicer: cover property (line_eff && !sync_q.line_src_ovr);
  c_bad_address: cover property (pslverr && pready);

endmodule : afe_ctrl_regs

// ### testbench/apb_host.sv
// apb master model standing in for the host controller
`timescale 1ns/1ps
module apb_host (
  // clock
  input  wire logic        pclk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // =====================================================================
  // idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // =====================================================================
  // one transfer; request held until pready is seen, bounded wait
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output logic to);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    to      = (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : apb_host

// ### testbench/tb_top.sv
// self-checking bench of the control register block
`timescale 1ns/1ps
module tb_top;
  // =====================================================================
  // clock, reset, bookkeeping
  logic        pclk    = 1'b0;
  logic        presetn = 1'b1;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          seed      = 40530;
  logic [7:0]  mdl [int];  // register model by index
  logic        psel, penable, pwrite, pready, pslverr, err, to;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        lin = 0, gin = 0, fin = 0, sep = 0, dlp = 0, dcp = 0;
  logic        cstr = 0, icl = 0, cin = 0, pck = 0;
  logic [47:0] pix = '0;
  logic [47:0] dout;
  logic [7:0]  v;
  afe_ctrl_pkg::sync_act_t act = 3'b111;
  logic [6:0]  ro, go, bo;
  logic [1:0]  pco;
  logic        clact, coact, lowp, lso, lsoe, fso, fsoe, pcoe, doe, gso;

  always #10 pclk = ~pclk;

  apb_host apb_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  afe_ctrl_regs afe_ctrl_regs_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_sync_in(lin),
    .green_sync_in(gin), .frame_sync_in(fin), .sep_frame_sync(sep), .sync_act(act),
    .det_line_pol_high(dlp), .det_coast_pol_high(dcp), .clamp_strobe_in(cstr),
    .int_clamp(icl), .coast_in(cin), .pix_clk_in(pck), .pix_data_in(pix),
    .red_offset_out(ro), .green_offset_out(go), .blue_offset_out(bo),
    .clamp_active(clact), .coast_active(coact), .low_power(lowp),
    .line_sync_out(lso), .line_sync_oe(lsoe), .frame_sync_out(fso),
    .frame_sync_oe(fsoe), .pixel_clock_out(pco), .pixel_clock_oe(pcoe),
    .data_out(dout), .data_oe(doe), .green_slicer_out(gso));

  // =====================================================================
  // comparisons and verdict
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t pin got %h exp %h", $time, got, exp);
    end
  endtask : chk_pin

  task automatic finish_test;
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  // =====================================================================
  // bus access; a hung transfer ends the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    apb_host_inst.xfer(w, a, {24'h0, d}, rd, err, to);
    if (to) begin
      error_cnt++;
      finish_test();
    end
  endtask : bus

  task automatic wr(input int idx, input logic [7:0] d);
    bus(1'b1, 8'(idx * 4), d);
    mdl[idx] = (idx == 14) ? d : d & 8'hfe;  // reserved bit 0 reads zero
  endtask : wr

  task automatic rd_chk(input int idx);
    bus(1'b0, 8'(idx * 4), 8'h00);
    chk_reg(rd, {24'h0, mdl[idx]});
  endtask : rd_chk

  // new random inputs, then two edges for the registered outputs
  task automatic settle;
    @(posedge pclk);
    {lin, gin, fin, sep, dlp, dcp} <= 6'($random(seed));
    {cstr, icl, cin, pck} <= 4'($random(seed));
    pix <= 48'({$random(seed), $random(seed)});
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle

  // =====================================================================
  // main sequence
  initial begin
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 11; i < 14; i++) mdl[i] = 8'h80;
    mdl[14] = 8'h40;
    mdl[15] = 8'h4e;
    for (int i = 11; i < 16; i++) rd_chk(i);
    // offsets: code 10h first, then random codes
    for (int i = 0; i < 6; i++) begin
      wr(11 + i % 3, (i == 0) ? 8'h20 : 8'($random(seed)));
      rd_chk(11 + i % 3);
    end
    settle();
    chk_pin(48'({ro, go, bo}), 48'({mdl[11][7:1], mdl[12][7:1], mdl[13][7:1]}));
    // every source and output polarity choice with overrides set, user line polarity high
    for (int i = 0; i < 16; i++) begin
      v = {2'b11, i[3], 1'b1, i[2], i[1], 1'b1, i[0]};
      wr(14, v);
      settle();
      chk_pin(48'((v[3] ? gin : lin) ^ v[5]), 48'(lso));
      chk_pin(48'((v[0] ? sep : fin) ^ !v[2]), 48'(fso));
      chk_pin(dout, pix);
    end
    // external clamp strobe both polarities, coast from pin
    for (int i = 0; i < 2; i++) begin
      v = i ? 8'hde : 8'h9e;
      wr(15, v);
      settle();
      chk_pin(48'(clact), 48'(cstr ^ v[6]));
      chk_pin(48'(coact), 48'(cin));
    end
    // automatic sources and polarities, internal clamp, coast from frame or pin
    wr(14, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr(15, i ? 8'h46 : 8'h26);
      settle();
      chk_pin(48'(lso), 48'(lin ^ !dlp));
      chk_pin(48'(fso), 48'(!fin));
      chk_pin(48'(clact), 48'(icl));
      chk_pin(48'(coact), 48'(i ? cin ^ !dcp : fin));
      chk_pin(48'(pco), 48'({!pck, pck}));
    end
    // full power down and back
    wr(15, 8'h4c);
    settle();
    chk_pin(48'({lsoe, fsoe, pcoe, doe, lowp}), 48'h01);
    chk_pin(48'(gso), 48'(gin));
    rd_chk(15);
    wr(15, 8'h4e);
    settle();
    chk_pin(48'({lsoe, fsoe, pcoe, doe, lowp}), 48'h1e);
    // idle syncs: seek, then seek forbidden
    act <= 3'b000;
    settle();
    chk_pin(48'({lsoe, fsoe, pcoe, doe, lowp}), 48'h01);
    chk_pin(48'(gso), 48'(gin));
    rd_chk(14);
    wr(15, 8'h4a);
    settle();
    chk_pin(48'({lsoe, fsoe, pcoe, doe, lowp}), 48'h1e);
    // automatic source reports: slicer only, then line pin only
    for (int i = 0; i < 2; i++) begin
      act <= i ? 3'b100 : 3'b010;
      settle();
      bus(1'b0, 8'h50, 8'h00);
      chk_reg(rd, i ? {24'h0, 2'b10, dlp, 5'h00} : {24'h0, 2'b01, dlp, 5'h0a});
    end
    // unmapped place is refused and reads zero
    bus(1'b0, 8'h40, 8'h00);
    chk_reg({rd[30:0], err}, 32'h1);
    finish_test();
  end
endmodule : tb_top
